// file: pkg/sacc_pkg.sv
// Purpose: Shared constants and types of the SAR converter control block
// Assumes: 10 MHz reference clock, 10-bit successive approximation
// Notes: Mode register layout is carried by sacc_mode_t
package sacc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_TIME_NS = 500;
    localparam int STEP_TIME_NS = 300;
    localparam int CNT_W = 4;
    // Least times, rounded up to whole cycles
    localparam logic [CNT_W-1:0] SAMPLE_CYC =
        CNT_W'((SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STEP_CYC =
        CNT_W'((STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // Result layout
    // ****************************************
    localparam int RES_BITS = 10;
    localparam int WIDE_BITS = 16;
    localparam int NARROW_BITS = 8;
    localparam int NARROW_LSB = 2;
    localparam logic [RES_BITS-1:0] SAR_SEED = 10'h200;
    localparam logic [3:0] SAR_TOP_IDX = 4'h9;
    localparam logic [3:0] SAR_LOW_IDX = 4'h0;

    // ****************************************
    // Registers
    // ****************************************
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] MODE_WMASK = 8'hB9;
    localparam logic [1:0] CHAN_RST = 2'h0;
    localparam logic [WIDE_BITS-1:0] WIDE_RST = 16'h0000;
    localparam logic [NARROW_BITS-1:0] NARROW_RST = 8'h00;

    typedef struct packed {
        logic start;
        logic rsvd_6;
        logic [2:0] conv_time;
        logic [1:0] rsvd_2_1;
        logic enable;
    } sacc_mode_t;

    typedef struct packed {
        logic [WIDE_BITS-1:0] wide;
        logic [NARROW_BITS-1:0] narrow;
    } sacc_result_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_STEP = 2'b10,
        ST_FINISH = 2'b11
    } sacc_state_t;

endpackage : sacc_pkg

// file: logic/sacc_sar_reg.sv
// Purpose: Successive approximation register with trial bit walk
// Assumes: Decision input already synchronised and settled
// Notes: o_last is high while the lowest bit is on trial
`timescale 1ns/100ps
module sacc_sar_reg (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_init,
    input wire logic i_decide,
    input wire logic i_above,
    output logic [sacc_pkg::RES_BITS-1:0] o_code,
    output logic o_last
);
    import sacc_pkg::*;

    logic [RES_BITS-1:0] code_r;
    logic [RES_BITS-1:0] code_nxt;
    logic [3:0] idx_r;
    logic [3:0] idx_nxt;
    logic [3:0] idx_dn;

    always_comb begin
        code_nxt = code_r;
        idx_nxt = idx_r;
        idx_dn = idx_r - 4'h1;
        if (i_init) begin
            code_nxt = SAR_SEED;
            idx_nxt = SAR_TOP_IDX;
        end else if (i_decide) begin
            if (!i_above) begin
                code_nxt[idx_r] = 1'b0;
            end
            if (idx_r != SAR_LOW_IDX) begin
                code_nxt[idx_dn] = 1'b1;
                idx_nxt = idx_dn;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            code_r <= '0;
            idx_r <= SAR_LOW_IDX;
        end else begin
            code_r <= code_nxt;
            idx_r <= idx_nxt;
        end
    end

    assign o_code = code_r;
    assign o_last = (idx_r == SAR_LOW_IDX);

endmodule : sacc_sar_reg

// file: logic/sacc_top.sv
// Purpose: Control of a 10-bit SAR converter with access conflict arbitration
// Assumes: Register accesses arrive as one-cycle strobes on the reference clock
// Notes: Comparator decision is an asynchronous input, synchronised here
`timescale 1ns/100ps
// Functional notes
// R1 - Setting the start bit converts the selected channel repeatedly until start is cleared.
// R2 - Each finished conversion loads both result registers and raises the end request.
// R3 - A mode or channel write aborts a running conversion and restarts it if start stays set.
// R4 - A result read in the update cycle gets the old value and the new one is stored after.
// R5 - A mode or channel write in the update cycle suppresses both the update and the request.
// R6 - A channel change leaves the end request flag untouched.
// R7 - A conversion of the old channel may still finish just before a channel rewrite.
// R8 - Software clears the end request flag before resuming stopped conversions.
// R9 - After a mode or channel write the result registers may hold stale contents.
// R10 - Software reads a finished result before writing mode or channel.
// R11 - Software clears start and enable before entering STOP.
// R12 - With start clear and enable set only the comparator stays powered while waiting.
// R13 - Software discards the first result if start followed enable too soon.
// R14 - Software keeps selected analog pins off alternate functions during conversion.
// R15 - Software leaves the shared port pins alone during conversion.
// R16 - Software may enter HALT right after start for better accuracy.
// R17 - Clearing start mid conversion stops at once with no end request.
module sacc_top (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_mode_wr,
    input wire logic [7:0] i_mode_wdata,
    input wire logic i_chan_wr,
    input wire logic [1:0] i_chan_wdata,
    input wire logic i_result_rd,
    input wire logic i_flag_clear,
    input wire logic i_cmp_above,
    output sacc_pkg::sacc_mode_t o_converter_mode_reg,
    output logic [1:0] o_input_channel_select_reg,
    output sacc_pkg::sacc_result_t o_conv_result,
    output logic o_conv_end_request_flag,
    output logic o_conv_end_interrupt,
    output logic [sacc_pkg::RES_BITS-1:0] o_dac_code,
    output logic o_sample_hold,
    output logic o_converter_active,
    output logic o_comparator_power
);
    import sacc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    sacc_mode_t mode_r;
    sacc_mode_t mode_nxt;
    logic [1:0] chan_r;
    logic [1:0] chan_nxt;
    sacc_state_t state_r;
    sacc_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] step_len;
    logic cmp_s1_r;
    logic cmp_s2_r;
    logic sar_init;
    logic sar_decide;
    logic sar_last;
    logic [RES_BITS-1:0] sar_code;
    logic wr_any;
    logic end_evt;
    logic take;
    logic store;
    logic pend_r;
    logic pend_nxt;
    sacc_result_t result_r;
    sacc_result_t result_nxt;
    logic flag_r;
    logic flag_nxt;
    logic irq_r;
    logic irq_nxt;

    // ****************************************
    // Comparator synchroniser
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            cmp_s1_r <= i_cmp_above;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // ****************************************
    // Mode and channel registers
    // ****************************************
    assign wr_any = i_mode_wr | i_chan_wr;

    always_comb begin
        mode_nxt = mode_r;
        chan_nxt = chan_r;
        if (i_mode_wr) begin
            mode_nxt = sacc_mode_t'(i_mode_wdata & MODE_WMASK);
        end
        if (i_chan_wr) begin
            chan_nxt = i_chan_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            mode_r <= sacc_mode_t'(MODE_RST);
            chan_r <= CHAN_RST;
        end else begin
            mode_r <= mode_nxt;
            chan_r <= chan_nxt;
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    // Decision waits covers DAC settle plus two synchroniser stages
    assign step_len = STEP_CYC + {1'b0, mode_r.conv_time};

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sar_init = 1'b0;
        sar_decide = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (mode_r.start) begin
                    state_nxt = ST_SAMPLE;
                    cnt_nxt = SAMPLE_CYC - 4'h1;
                end
            end
            ST_SAMPLE: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_STEP;
                    cnt_nxt = step_len - 4'h1;
                    sar_init = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_STEP: begin
                if (cnt_r == '0) begin
                    sar_decide = 1'b1;
                    cnt_nxt = step_len - 4'h1;
                    if (sar_last) begin
                        state_nxt = ST_FINISH;
                    end
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_FINISH: begin
                // Next conversion starts at once
                state_nxt = mode_r.start ? ST_SAMPLE : ST_IDLE; // R1
                cnt_nxt = SAMPLE_CYC - 4'h1;
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt = '0;
            end
        endcase
        if (wr_any) begin
            // Abort, restart only with start still set
            state_nxt = mode_nxt.start ? ST_SAMPLE : ST_IDLE; // R3 R17
            cnt_nxt = SAMPLE_CYC - 4'h1;
            sar_init = 1'b0;
            sar_decide = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    sacc_sar_reg u_sar (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_init(sar_init),
        .i_decide(sar_decide),
        .i_above(cmp_s2_r),
        .o_code(sar_code),
        .o_last(sar_last)
    );

    // ****************************************
    // Result update and end request
    // ****************************************
    // Old channel result still lands if it finishes before the write
    assign end_evt = (state_r == ST_FINISH) && !wr_any; // R5 R7
    assign take = end_evt | pend_r;
    assign store = take && !i_result_rd && !wr_any; // R4 R5 R9

    always_comb begin
        pend_nxt = take && i_result_rd && !wr_any; // R4
        result_nxt = result_r;
        if (store) begin
            result_nxt.wide = {{(WIDE_BITS-RES_BITS){1'b0}}, sar_code}; // R2
            result_nxt.narrow = sar_code[RES_BITS-1:NARROW_LSB]; // R2
        end
        irq_nxt = store; // R2
        // Set wins over clear; channel writes never touch it
        if (store) begin
            flag_nxt = 1'b1; // R2
        end else if (i_flag_clear) begin
            flag_nxt = 1'b0;
        end else begin
            flag_nxt = flag_r; // R6
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            pend_r <= 1'b0;
            result_r <= {WIDE_RST, NARROW_RST};
            flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            result_r <= result_nxt;
            flag_r <= flag_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_converter_mode_reg = mode_r;
    assign o_input_channel_select_reg = chan_r;
    assign o_conv_result = result_r;
    assign o_conv_end_request_flag = flag_r;
    assign o_conv_end_interrupt = irq_r;
    assign o_dac_code = sar_code;
    assign o_sample_hold = (state_r == ST_SAMPLE);
    assign o_converter_active = (state_r != ST_IDLE);
    assign o_comparator_power = mode_r.enable | (state_r != ST_IDLE); // R12

    // ****************************************
    // Assertions
    // ****************************************
    a_start_leaves_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_mode_wr && i_mode_wdata[7] |=> state_r == ST_SAMPLE && o_sample_hold) // R1
        else $error("start did not begin sampling");
    a_repeat_conv: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_r == ST_FINISH && mode_r.start && !wr_any |=> state_r == ST_SAMPLE) // R1
        else $error("conversion did not repeat");
    a_irq_sets_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_conv_end_interrupt) |-> o_conv_end_request_flag) // R2
        else $error("interrupt without request flag");
    a_write_restarts: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_any |=> (state_r == ST_SAMPLE) == mode_r.start && cnt_r == SAMPLE_CYC - 4'h1) // R3
        else $error("write did not restart sequence");
    a_read_holds_old: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_result_rd |=> $stable(o_conv_result)) // R4
        else $error("result changed under a read");
    a_read_then_new: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        end_evt && i_result_rd ##1 !i_result_rd && !wr_any |=> o_conv_end_interrupt) // R4
        else $error("deferred result not stored");
    a_write_blocks_end: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_r == ST_FINISH && wr_any |=> !o_conv_end_interrupt && $stable(o_conv_result)) // R5
        else $error("write did not suppress update");
    a_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_conv_end_request_flag && !i_flag_clear |=> o_conv_end_request_flag) // R6
        else $error("request flag lost");
    a_stop_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_mode_wr && !i_mode_wdata[7] && state_r != ST_IDLE
        |=> (state_r == ST_IDLE && !o_conv_end_interrupt) [*2]) // R17
        else $error("stop did not halt conversion");
    a_waiting_power: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_r == ST_IDLE && mode_r.enable |-> o_comparator_power && !o_converter_active) // R12
        else $error("waiting state power wrong");

    c_conv_done: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_conv_end_interrupt ##[1:200] o_conv_end_interrupt);
    c_read_conflict: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        end_evt && i_result_rd);
    c_write_conflict: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_r == ST_FINISH && wr_any);
    c_set_over_clear: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        store && i_flag_clear);

endmodule : sacc_top

// file: dv/sacc_analog_model.sv
// Purpose: Analog side model: comparator against a held input level
// Assumes: DAC code settles within the cycle it is driven
// Notes: Above is high when the input is at or over the trial tap
`timescale 1ns/100ps
module sacc_analog_model (
    input wire logic i_hold,
    input wire logic [9:0] i_vin,
    input wire logic [9:0] i_dac_code,
    output logic o_cmp_above
);
    logic [9:0] held;

    // Track the input while sampling, frozen for the steps
    always_latch begin
        if (i_hold) begin
            held <= i_vin;
        end
    end

    assign o_cmp_above = (held >= i_dac_code);
endmodule : sacc_analog_model

// file: dv/testbench.sv
// Purpose: Self-checking bench of the SAR converter control block
// Assumes: Bench acts as host software, strobes driven at falling edges
// Notes: Conversion time field 0 takes 36 cycles a conversion, field 1 takes 46
`timescale 1ns/100ps
module testbench;
    import sacc_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_mode_wr = 1'b0;
    logic [7:0] i_mode_wdata = 8'h00;
    logic i_chan_wr = 1'b0;
    logic [1:0] i_chan_wdata = 2'h0;
    logic i_result_rd = 1'b0;
    logic i_flag_clear = 1'b0;
    logic i_cmp_above;
    logic [9:0] vin = 10'h000;
    sacc_mode_t mode;
    logic [1:0] chan;
    sacc_result_t res;
    logic flag, irq, hold, active, power;
    logic [9:0] dac;
    int miscompares = 0;
    int checked = 0;
    int n;

    always #50 i_ref_clk = ~i_ref_clk;

    sacc_top DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_mode_wr(i_mode_wr),
        .i_mode_wdata(i_mode_wdata), .i_chan_wr(i_chan_wr), .i_chan_wdata(i_chan_wdata),
        .i_result_rd(i_result_rd), .i_flag_clear(i_flag_clear), .i_cmp_above(i_cmp_above),
        .o_converter_mode_reg(mode), .o_input_channel_select_reg(chan),
        .o_conv_result(res), .o_conv_end_request_flag(flag), .o_conv_end_interrupt(irq),
        .o_dac_code(dac), .o_sample_hold(hold), .o_converter_active(active),
        .o_comparator_power(power));

    sacc_analog_model u_analog (.i_hold(hold), .i_vin(vin), .i_dac_code(dac),
        .o_cmp_above(i_cmp_above));

    function automatic logic [23:0] exp_res(input logic [9:0] v);
        return {6'h00, v, v[9:2]};
    endfunction : exp_res

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic cmp_v(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_v

    task automatic cmp_n(input int got, input int exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_n

    task automatic strobe(ref logic s);
        @(negedge i_ref_clk);
        s = 1'b1;
        @(negedge i_ref_clk);
        s = 1'b0;
    endtask : strobe

    task automatic wr_mode(input logic [7:0] d);
        i_mode_wdata = d;
        strobe(i_mode_wr);
    endtask : wr_mode

    task automatic wr_chan(input logic [1:0] c);
        i_chan_wdata = c;
        strobe(i_chan_wr);
    endtask : wr_chan

    // Cycles until the end interrupt, 0 when none within the bound
    task automatic wait_irq(input int bound, output int cyc);
        cyc = 1;
        while (cyc <= bound && irq !== 1'b1) begin
            @(negedge i_ref_clk);
            cyc++;
        end
        if (cyc > bound) begin
            cyc = 0;
        end
    endtask : wait_irq

    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_rstn = 1'b1;
        cmp_v({mode, res, flag, power}, 34'h0);
        // ****************************************
        // Start, store, back-to-back repeat
        // ****************************************
        wr_chan(2'h1);
        vin = 10'h2A5;
        wr_mode(8'h81);
        cmp_v({mode, hold, active}, {8'h81, 2'b11});
        wait_irq(100, n);
        cmp_n(n, 37);
        cmp_v(res, exp_res(10'h2A5));
        cmp_v(flag, 1'b1);
        vin = 10'h15A;
        @(negedge i_ref_clk);
        wait_irq(100, n);
        cmp_n(n, 36);
        cmp_v(res, exp_res(10'h15A));
        // ****************************************
        // Channel change mid conversion
        // ****************************************
        vin = 10'h3FF;
        strobe(i_result_rd);
        wr_chan(2'h2);
        cmp_v(chan, 2'h2);
        cmp_v(flag, 1'b1);
        wait_irq(100, n);
        cmp_n(n, 37);
        cmp_v(res, exp_res(10'h3FF));
        // ****************************************
        // Stop mid conversion, waiting state
        // ****************************************
        vin = 10'h001;
        wr_mode(8'h47);
        cmp_v(mode, 8'h01);
        wait_irq(60, n);
        cmp_n(n, 0);
        cmp_v({active, power}, 2'b01);
        cmp_v(res, exp_res(10'h3FF));
        wr_mode(8'h00);
        cmp_v(power, 1'b0);
        strobe(i_flag_clear);
        cmp_v(flag, 1'b0);
        // ****************************************
        // Read in the finish cycle defers the store
        // ****************************************
        wr_mode(8'h81);
        repeat (35) @(negedge i_ref_clk);
        i_result_rd = 1'b1;
        @(negedge i_ref_clk);
        cmp_v({irq, res}, {1'b0, exp_res(10'h3FF)});
        i_result_rd = 1'b0;
        @(negedge i_ref_clk);
        cmp_v({irq, res}, {1'b1, exp_res(10'h001)});
        // ****************************************
        // Mode write in the finish cycle wins
        // ****************************************
        strobe(i_flag_clear);
        wr_mode(8'h81);
        vin = 10'h0C3;
        repeat (34) @(negedge i_ref_clk);
        wr_mode(8'h81);
        cmp_v({flag, res}, {1'b0, exp_res(10'h001)});
        wait_irq(60, n);
        cmp_n(n, 37);
        cmp_v(res, exp_res(10'h0C3));
        // ****************************************
        // Longer step time from the mode field
        // ****************************************
        vin = 10'h1B6;
        wr_mode(8'h89);
        cmp_v(mode, 8'h89);
        repeat (5) @(negedge i_ref_clk);
        cmp_v(dac, 10'h200);
        wait_irq(100, n);
        cmp_n(n, 42);
        cmp_v(res, exp_res(10'h1B6));
        close_out();
    end

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        miscompares++;
        close_out();
    end
endmodule : testbench
